// ==== flash_id_sec_pkg.sv ====
// Functional notes
// - unique-id read: 4Bh then four dummy bytes
// - four-byte mode: five dummy bytes instead
// - 64-bit unique id out on falling edges
// - 9Fh returns maker, type, capacity bytes, MSB first
// - 5Ah, 24-bit address, 8 dummies, data clock 40
// - parameter table: upper address zero, A7-A0 start byte
// - parameter read always uses 24-bit address
// - three 256-byte security registers, selected by A15-A12
// - erase 44h needs write enable latch set
// - erase runs only if select rises after address
// - self-timed erase holds busy, status stays readable
// - erase end clears write enable latch and busy; a wen_set_i pulse in that same cycle keeps the latch set
// - lock bit set blocks erase and program
// - program 42h: 1-256 bytes, only clears bits
// - program needs write enable latch set
// - read 48h: address, 8 dummies, data until deselect
// - read address increments, wraps FFh to 00h
// - security read ignored while busy
// - four-byte mode: security commands take 32-bit address
package flash_id_sec_pkg;

   // opcodes
   localparam logic [7:0] OPC_UID      = 8'h4B;
   localparam logic [7:0] OPC_JEDEC    = 8'h9F;
   localparam logic [7:0] OPC_SFDP     = 8'h5A;
   localparam logic [7:0] OPC_SEC_ERS  = 8'h44;
   localparam logic [7:0] OPC_SEC_PRG  = 8'h42;
   localparam logic [7:0] OPC_SEC_RD   = 8'h48;

   // phase lengths, as last bit index of the phase
   localparam logic [5:0] OPC_LAST      = 6'h07;
   localparam logic [5:0] ADDR_LAST_3B  = 6'h17;
   localparam logic [5:0] ADDR_LAST_4B  = 6'h1F;
   localparam logic [5:0] UID_DUMMY_3B  = 6'h1F;
   localparam logic [5:0] UID_DUMMY_4B  = 6'h27;
   localparam logic [5:0] RD_DUMMY_LAST = 6'h07;
   localparam logic [2:0] BIT_MSB       = 3'h7;

   // security register map
   localparam logic [3:0] SEC_SEL_LO  = 4'h1;
   localparam logic [3:0] SEC_SEL_HI  = 4'h3;
   localparam int         SEC_DEPTH   = 768;
   localparam int         MEM_IDX_W   = 10;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] JEDEC_LAST  = 8'h02;

   // identity values, all arbitrary
   localparam logic [7:0]  MFR_ID        = 8'hA5;
   localparam logic [7:0]  MEM_TYPE_ID   = 8'h3C;
   localparam logic [7:0]  CAPACITY_ID   = 8'h1A;
   localparam logic [63:0] UNIQUE_ID     = 64'h0123456789ABCDEF;

   // timing
   localparam int unsigned CORE_CLK_MHZ = 50;
   localparam int          TIMER_W      = 32;

   typedef enum logic [2:0] {
      PH_OPC    = 3'b000,
      PH_ADDR   = 3'b001,
      PH_DUMMY  = 3'b010,
      PH_DATA   = 3'b011,
      PH_TAIL   = 3'b100,
      PH_IGNORE = 3'b101
   } phase_t;

   typedef enum logic [2:0] {
      SRC_NONE  = 3'b000,
      SRC_UID   = 3'b001,
      SRC_JEDEC = 3'b010,
      SRC_SFDP  = 3'b011,
      SRC_RD    = 3'b100,
      SRC_PRG   = 3'b101,
      SRC_ERS   = 3'b110
   } src_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ERASE = 2'b01,
      ST_PROG  = 2'b10
   } core_state_t;

   // core status handed to the link side
   typedef struct packed {
      logic       addr4;
      logic       busy;
      logic       wen;
      logic [2:0] locks;
   } status_t;

   // one byte access request from link to storage
   typedef struct packed {
      logic                 wr;
      logic [MEM_IDX_W-1:0] idx;
      logic [7:0]           data;
   } mem_req_t;

   // parameter table contents: signature then erased bytes
   function automatic logic [7:0] sfdp_byte(input logic [7:0] a);
      case (a)
         8'h00:   sfdp_byte = 8'h53;
         8'h01:   sfdp_byte = 8'h46;
         8'h02:   sfdp_byte = 8'h44;
         8'h03:   sfdp_byte = 8'h50;
         default: sfdp_byte = ERASED_BYTE;
      endcase
   endfunction : sfdp_byte

endpackage : flash_id_sec_pkg

// ==== flash_id_sec_cmd.sv ====
`timescale 1ns/1ps
module flash_id_sec_cmd
   import flash_id_sec_pkg::*;
#(
   parameter int unsigned ERASE_TIME_US = 1000,
   parameter int unsigned PROG_TIME_US  = 200
)
(
   // core clock domain
   input  wire logic       core_clk_i,
   input  wire logic       nrst_i,
   input  wire logic       ce_i,
   // serial link, clocked by the host
   input  wire logic       sclk_i,
   input  wire logic       cs_n_i,
   input  wire logic       serial_in_i,
   output logic            serial_out_o,
   output logic            serial_out_en_o,
   // status and control, core domain
   input  wire logic       addr4_mode_i,
   input  wire logic       other_busy_i,
   input  wire logic       wen_set_i,
   input  wire logic [2:0] security_otp_lock_bits_i,
   output logic            busy_o,
   output logic            write_enable_latch_o
);

   localparam int unsigned ERASE_CYCLES = ERASE_TIME_US * CORE_CLK_MHZ;
   localparam int unsigned PROG_CYCLES  = PROG_TIME_US * CORE_CLK_MHZ;

   // link side state, cleared while deselected
   phase_t               phase_reg, phase_next;
   src_t                 src_reg, src_next;
   logic [5:0]           cnt_reg, cnt_next;
   logic [5:0]           len_reg, len_next;
   logic [31:0]          sh_reg, sh_next;
   logic [7:0]           ptr_reg, ptr_next;
   logic [1:0]           sel_reg, sel_next;
   logic [2:0]           bit_reg, bit_next;
   logic [7:0]           tx_reg, tx_next;
   // link side state kept across frames
   logic                 frame_tgl_reg;
   logic                 erase_ok_reg;
   logic                 prog_seen_reg;
   logic [1:0]           erase_sel_reg;
   mem_req_t             req_reg, req_next;
   logic                 req_tgl_reg;
   logic                 ack_s1_reg, ack_s2_reg, ack_seen_reg;
   logic [7:0]           fetch_reg;
   status_t              stat_s1_reg, stat_s2_reg;
   // link combinational helpers
   logic                 fire, erase_set, first_edge, link_rst;
   logic                 hi_zero, addr_ok;
   logic [3:0]           sel_field;
   logic [7:0]           src_byte, ptr_inc;
   // core side
   core_state_t          state_reg;
   logic [TIMER_W-1:0]   timer_reg;
   logic [8:0]           wipe_reg;
   logic [1:0]           wipe_sel_reg;
   logic                 frame_seen_reg;
   logic                 cs_s1_reg, cs_s2_reg, cs_s3_reg;
   logic                 frm_s1_reg, frm_s2_reg;
   logic                 eok_s1_reg, eok_s2_reg;
   logic                 prg_s1_reg, prg_s2_reg;
   logic [1:0]           esel_s1_reg, esel_s2_reg;
   logic                 rq_s1_reg, rq_s2_reg, rq_s3_reg;
   logic                 ack_tgl_reg;
   logic [7:0]           rd_data_reg;
   status_t              status_reg;
   logic                 cs_rise, req_edge, wipe_we;
   logic [MEM_IDX_W-1:0] wipe_idx;
   logic [7:0]           mem_reg [SEC_DEPTH];

   // link logic idles whenever select is high
   assign link_rst   = cs_n_i | ~nrst_i;
   assign first_edge = (phase_reg == PH_OPC) && (cnt_reg == 6'h00);

   // address checks on the completed address word
   assign sel_field = sh_next[15:12];
   assign hi_zero   = stat_s2_reg.addr4 ? (sh_next[31:16] == 16'h0000)
                                         : (sh_next[23:16] == 8'h00);
   assign addr_ok   = hi_zero && (sel_field >= SEC_SEL_LO) && (sel_field <= SEC_SEL_HI)
                      && (sh_next[11:8] == 4'h0);

   // byte for the current source and pointer
   always_comb
   begin
      unique case (src_reg)
         SRC_JEDEC:
         begin
            src_byte = (ptr_reg == 8'h00) ? MFR_ID
                     : (ptr_reg == 8'h01) ? MEM_TYPE_ID : CAPACITY_ID;
         end
         SRC_UID:  src_byte = UNIQUE_ID[{~ptr_reg[2:0], 3'h7} -: 8];
         SRC_SFDP: src_byte = sfdp_byte(ptr_reg);
         SRC_RD:   src_byte = fetch_reg;
         default:  src_byte = ERASED_BYTE;
      endcase
      // id bytes cycle; table and registers wrap at the byte boundary
      ptr_inc = ((src_reg == SRC_JEDEC) && (ptr_reg == JEDEC_LAST)) ? 8'h00 : ptr_reg + 8'h01;
   end

   // command sequencer, one step per rising link edge
   always_comb
   begin
      phase_next = phase_reg;
      src_next   = src_reg;
      cnt_next   = cnt_reg + 6'h01;
      len_next   = len_reg;
      sh_next    = {sh_reg[30:0], serial_in_i};
      ptr_next   = ptr_reg;
      sel_next   = sel_reg;
      bit_next   = bit_reg;
      tx_next    = tx_reg;
      req_next   = req_reg;
      fire       = 1'b0;
      erase_set  = 1'b0;
      unique case (phase_reg)
         PH_OPC:
         begin
            if (cnt_reg == OPC_LAST)
            begin
               cnt_next = 6'h00;
               unique case (sh_next[7:0])
                  OPC_UID:
                  begin
                     phase_next = PH_DUMMY;
                     src_next   = SRC_UID;
                     ptr_next   = 8'h00;
                     len_next   = stat_s2_reg.addr4 ? UID_DUMMY_4B : UID_DUMMY_3B;
                  end
                  OPC_JEDEC:
                  begin
                     phase_next = PH_DATA; // no address, no dummy
                     src_next   = SRC_JEDEC;
                     tx_next    = MFR_ID;
                     ptr_next   = 8'h01;
                     bit_next   = BIT_MSB;
                  end
                  OPC_SFDP:
                  begin
                     phase_next = PH_ADDR;
                     src_next   = SRC_SFDP;
                     len_next   = ADDR_LAST_3B;
                  end
                  OPC_SEC_RD, OPC_SEC_PRG, OPC_SEC_ERS:
                  begin
                     // busy device ignores the whole frame
                     phase_next = stat_s2_reg.busy ? PH_IGNORE : PH_ADDR;
                     src_next   = (sh_next[7:0] == OPC_SEC_RD) ? SRC_RD
                                : (sh_next[7:0] == OPC_SEC_PRG) ? SRC_PRG : SRC_ERS;
                     len_next   = stat_s2_reg.addr4 ? ADDR_LAST_4B : ADDR_LAST_3B;
                  end
                  default: phase_next = PH_IGNORE;
               endcase
            end
         end
         PH_ADDR:
         begin
            if (cnt_reg == len_reg)
            begin
               cnt_next = 6'h00;
               ptr_next = sh_next[7:0];
               sel_next = 2'(sel_field - SEC_SEL_LO);
               unique case (src_reg)
                  SRC_SFDP:
                  begin
                     phase_next = PH_DUMMY; // upper address bits are not decoded
                     len_next   = RD_DUMMY_LAST;
                  end
                  SRC_RD:
                  begin
                     phase_next = addr_ok ? PH_DUMMY : PH_IGNORE;
                     len_next   = RD_DUMMY_LAST;
                     // prefetch the first byte during the dummy clocks
                     fire       = addr_ok;
                     req_next   = '{wr: 1'b0, idx: {2'(sel_field - SEC_SEL_LO), sh_next[7:0]}, data: 8'h00};
                  end
                  SRC_PRG:
                  begin
                     phase_next = (addr_ok && stat_s2_reg.wen && !stat_s2_reg.locks[2'(sel_field - SEC_SEL_LO)])
                                  ? PH_DATA : PH_IGNORE;
                     bit_next   = BIT_MSB;
                  end
                  default:
                  begin
                     phase_next = PH_TAIL;
                     erase_set  = addr_ok && stat_s2_reg.wen
                                  && !stat_s2_reg.locks[2'(sel_field - SEC_SEL_LO)];
                  end
               endcase
            end
         end
         PH_DUMMY:
         begin
            if (cnt_reg == len_reg)
            begin
               phase_next = PH_DATA;
               bit_next   = BIT_MSB;
               tx_next    = src_byte; // first bit leaves on this falling edge
               ptr_next   = ptr_inc;
               fire       = (src_reg == SRC_RD);
               req_next   = '{wr: 1'b0, idx: {sel_reg, ptr_inc}, data: 8'h00};
            end
         end
         PH_DATA:
         begin
            bit_next = bit_reg - 3'h1;
            if (bit_reg == 3'h0)
            begin
               bit_next = BIT_MSB;
               if (src_reg == SRC_PRG)
               begin
                  // each whole data byte goes straight to storage
                  fire     = 1'b1;
                  req_next = '{wr: 1'b1, idx: {sel_reg, ptr_reg}, data: sh_next[7:0]};
                  ptr_next = ptr_reg + 8'h01;
               end
               else
               begin
                  tx_next  = src_byte;
                  ptr_next = ptr_inc;
                  fire     = (src_reg == SRC_RD);
                  req_next = '{wr: 1'b0, idx: {sel_reg, ptr_inc}, data: 8'h00};
               end
            end
         end
         default: cnt_next = cnt_reg; // tail and ignore just wait for deselect
      endcase
   end

   // sequencer registers, cleared by deselect
   always_ff @(posedge sclk_i or posedge link_rst)
   begin
      if (link_rst)
      begin
         phase_reg <= PH_OPC;
         src_reg   <= SRC_NONE;
         cnt_reg   <= 6'h00;
         len_reg   <= 6'h00;
         sh_reg    <= 32'h0000_0000;
         ptr_reg   <= 8'h00;
         sel_reg   <= 2'h0;
         bit_reg   <= BIT_MSB;
         tx_reg    <= 8'h00;
      end
      else
      begin
         phase_reg <= phase_next;
         src_reg   <= src_next;
         cnt_reg   <= cnt_next;
         len_reg   <= len_next;
         sh_reg    <= sh_next;
         ptr_reg   <= ptr_next;
         sel_reg   <= sel_next;
         bit_reg   <= bit_next;
         tx_reg    <= tx_next;
      end
   end

   // frame outcome flags, which must survive the rising select
   always_ff @(posedge sclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         frame_tgl_reg <= 1'b0;
         erase_ok_reg  <= 1'b0;
         prog_seen_reg <= 1'b0;
         erase_sel_reg <= 2'h0;
      end
      else if (first_edge)
      begin
         frame_tgl_reg <= ~frame_tgl_reg; // lets the core skip frames with no clocks
         erase_ok_reg  <= 1'b0;
         prog_seen_reg <= 1'b0;
      end
      else
      begin
         // any clock after the last address bit cancels the erase
         if (erase_set)
         begin
            erase_ok_reg  <= 1'b1;
            erase_sel_reg <= sel_next;
         end
         else if (phase_reg == PH_TAIL)
         begin
            erase_ok_reg <= 1'b0;
         end
         if (fire && req_next.wr)
         begin
            prog_seen_reg <= 1'b1; // at least one byte
         end
      end
   end

   // request toggle to storage, data captured on returning acknowledge
   always_ff @(posedge sclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         req_reg      <= '0;
         req_tgl_reg  <= 1'b0;
         ack_s1_reg   <= 1'b0;
         ack_s2_reg   <= 1'b0;
         ack_seen_reg <= 1'b0;
         fetch_reg    <= ERASED_BYTE;
         stat_s1_reg  <= '0;
         stat_s2_reg  <= '0;
      end
      else
      begin
         ack_s1_reg  <= ack_tgl_reg;
         ack_s2_reg  <= ack_s1_reg;
         // status chain refreshes within the eight opcode clocks
         stat_s1_reg <= status_reg;
         stat_s2_reg <= stat_s1_reg;
         if (fire)
         begin
            req_reg     <= req_next;
            req_tgl_reg <= ~req_tgl_reg;
         end
         if (ack_s2_reg != ack_seen_reg)
         begin
            ack_seen_reg <= ack_s2_reg;
            fetch_reg    <= rd_data_reg;
         end
      end
   end

   // output pin changes on falling edges, and clears at once when select rises
   always_ff @(negedge sclk_i or posedge link_rst)
   begin
      if (link_rst)
      begin
         serial_out_o    <= 1'b0;
         serial_out_en_o <= 1'b0;
      end
      else
      begin
         serial_out_o    <= tx_reg[bit_reg]; // msb first
         serial_out_en_o <= (phase_reg == PH_DATA) && (src_reg != SRC_PRG);
      end
   end

   assign cs_rise  = cs_s2_reg & ~cs_s3_reg;
   assign req_edge = rq_s2_reg ^ rq_s3_reg;
   assign wipe_we  = (state_reg == ST_ERASE) && !wipe_reg[8];
   assign wipe_idx = {wipe_sel_reg, wipe_reg[7:0]};

   // synchronisers for link signals entering the core domain
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cs_s1_reg   <= 1'b1;
         cs_s2_reg   <= 1'b1;
         cs_s3_reg   <= 1'b1;
         frm_s1_reg  <= 1'b0;
         frm_s2_reg  <= 1'b0;
         eok_s1_reg  <= 1'b0;
         eok_s2_reg  <= 1'b0;
         prg_s1_reg  <= 1'b0;
         prg_s2_reg  <= 1'b0;
         esel_s1_reg <= 2'h0;
         esel_s2_reg <= 2'h0;
         rq_s1_reg   <= 1'b0;
         rq_s2_reg   <= 1'b0;
         rq_s3_reg   <= 1'b0;
      end
      else if (ce_i)
      begin
         cs_s1_reg   <= cs_n_i;
         cs_s2_reg   <= cs_s1_reg;
         cs_s3_reg   <= cs_s2_reg;
         frm_s1_reg  <= frame_tgl_reg;
         frm_s2_reg  <= frm_s1_reg;
         eok_s1_reg  <= erase_ok_reg;
         eok_s2_reg  <= eok_s1_reg;
         prg_s1_reg  <= prog_seen_reg;
         prg_s2_reg  <= prg_s1_reg;
         esel_s1_reg <= erase_sel_reg;
         esel_s2_reg <= esel_s1_reg;
         rq_s1_reg   <= req_tgl_reg;
         rq_s2_reg   <= rq_s1_reg;
         rq_s3_reg   <= rq_s2_reg;
      end
   end

   // self-timed erase and program cycles
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state_reg      <= ST_IDLE;
         timer_reg      <= '0;
         wipe_reg       <= 9'h000;
         wipe_sel_reg   <= 2'h0;
         frame_seen_reg <= 1'b0;
         busy_o         <= 1'b0;
      end
      else if (ce_i)
      begin
         if (cs_rise)
         begin
            frame_seen_reg <= frm_s2_reg;
         end
         unique case (state_reg)
            ST_IDLE:
            begin
               if (cs_rise && (frm_s2_reg != frame_seen_reg) && eok_s2_reg)
               begin
                  state_reg    <= ST_ERASE;
                  timer_reg    <= TIMER_W'(ERASE_CYCLES - 1);
                  wipe_reg     <= 9'h000;
                  wipe_sel_reg <= esel_s2_reg;
                  busy_o       <= 1'b1;
               end
               else if (cs_rise && (frm_s2_reg != frame_seen_reg) && prg_s2_reg)
               begin
                  state_reg <= ST_PROG;
                  timer_reg <= TIMER_W'(PROG_CYCLES - 1);
                  busy_o    <= 1'b1;
               end
            end
            default:
            begin
               // wipe walks one byte a cycle, well inside the erase time
               if (wipe_we)
               begin
                  wipe_reg <= wipe_reg + 9'h001;
               end
               if (timer_reg == '0)
               begin
                  state_reg <= ST_IDLE;
                  busy_o    <= 1'b0;
               end
               else
               begin
                  timer_reg <= timer_reg - TIMER_W'(1);
               end
            end
         endcase
      end
   end

   // write enable latch, a set pulse wins over the end-of-cycle clear
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         write_enable_latch_o <= 1'b0;
      end
      else if (ce_i)
      begin
         if (wen_set_i)
         begin
            write_enable_latch_o <= 1'b1;
         end
         else if ((state_reg != ST_IDLE) && (timer_reg == '0))
         begin
            write_enable_latch_o <= 1'b0;
         end
      end
   end

   // status snapshot for the link side, registered so its chain sees no glitches
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         status_reg <= '0;
      end
      else if (ce_i)
      begin
         status_reg <= '{addr4: addr4_mode_i, busy: busy_o | other_busy_i,
                         wen: write_enable_latch_o, locks: security_otp_lock_bits_i};
      end
   end

   // read port answers each link request with a toggle
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         ack_tgl_reg <= 1'b0;
         rd_data_reg <= ERASED_BYTE;
      end
      else if (ce_i && req_edge)
      begin
         ack_tgl_reg <= rq_s2_reg;
         if (!req_reg.wr)
         begin
            rd_data_reg <= mem_reg[req_reg.idx];
         end
      end
   end

   // security register storage, one flop byte per entry
   generate
      for (genvar i = 0; i < SEC_DEPTH; i++)
      begin : g_entry
         always_ff @(posedge core_clk_i or negedge nrst_i)
         begin
            if (!nrst_i)
            begin
               mem_reg[i] <= ERASED_BYTE;
            end
            else if (ce_i)
            begin
               if (wipe_we && (wipe_idx == MEM_IDX_W'(i)))
               begin
                  mem_reg[i] <= ERASED_BYTE;
               end
               else if (req_edge && req_reg.wr && (req_reg.idx == MEM_IDX_W'(i)))
               begin
                  mem_reg[i] <= mem_reg[i] & req_reg.data; // bits only go to zero
               end
            end
         end
      end
   endgenerate

endmodule : flash_id_sec_cmd

// ==== flash_id_sec_cmd_chk.sv ====
`timescale 1ns/1ps
module flash_id_sec_cmd_chk
(
   // watched ports
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic cs_n_i,
   input wire logic wen_set_i,
   input wire logic serial_out_o,
   input wire logic serial_out_en_o,
   input wire logic busy_o,
   input wire logic write_enable_latch_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   // deselect must silence the pin at once
   AST_IDLE_EN: assert property (cs_n_i |-> !serial_out_en_o) else $error("driving while deselected");
   AST_IDLE_OUT: assert property (cs_n_i |-> !serial_out_o) else $error("data while deselected");
   AST_WEN_SET: assert property (wen_set_i && ce_i |=> write_enable_latch_o) else $error("latch not set");
   AST_WEN_CAUSE: assert property ($rose(write_enable_latch_o) |-> $past(wen_set_i)) else $error("latch set");
   AST_BUSY_WEN: assert property ($rose(busy_o) |-> $past(write_enable_latch_o)) else $error("busy no latch");
   AST_BUSY_CS: assert property ($rose(busy_o) |-> cs_n_i) else $error("busy while selected");
   AST_BUSY_MIN: assert property ($rose(busy_o) |-> busy_o [*8]) else $error("busy too short");
   AST_END_WEN: assert property ($fell(busy_o) |-> !write_enable_latch_o) else $error("latch kept");
endmodule : flash_id_sec_cmd_chk

bind flash_id_sec_cmd flash_id_sec_cmd_chk i_flash_id_sec_cmd_chk (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
   .ce_i(ce_i), .cs_n_i(cs_n_i), .wen_set_i(wen_set_i), .serial_out_o(serial_out_o),
   .serial_out_en_o(serial_out_en_o), .busy_o(busy_o), .write_enable_latch_o(write_enable_latch_o));

// ==== spi_host_model.sv ====
`timescale 1ns/1ps
module spi_host_model
(
   // link pins
   output logic     sclk_o,
   output logic     cs_n_o,
   output logic     mosi_o,
   input wire logic miso_i
);
   initial
   begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   // one frame, tx msb-aligned; clock parks low outside frames
   task frame(input logic [63:0] tx, input int ntx, input int nrx, output logic [63:0] rx);
      rx = '0;
      cs_n_o = 1'b0;
      for (int i = 0; i < ntx; i++)
      begin
         mosi_o = tx[63-i];
         #16 sclk_o = 1'b1;
         #16 sclk_o = 1'b0;
      end
      for (int i = 0; i < nrx; i++)
      begin
         mosi_o = ~mosi_o; // input toggles each read clock, so no stale level
         #16 sclk_o = 1'b1;
         rx = {rx[62:0], miso_i};
         #16 sclk_o = 1'b0;
      end
      #16 cs_n_o = 1'b1;
      #200;
   endtask : frame
endmodule : spi_host_model

// ==== test_flash_id_sec_cmd.sv ====
`timescale 1ns/1ps
module test_flash_id_sec_cmd;
   import flash_id_sec_pkg::*;
   logic        core_clk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        addr4 = 1'b0, obusy = 1'b0, wen = 1'b0, en_seen;
   logic [2:0]  lock = 3'h0;
   logic        sclk, cs_n, mosi, miso, oen, busy, latch;
   logic [63:0] rx;
   int          miscompares = 0, tests_run = 0;
   always #10 core_clk_i = ~core_clk_i;
   always @(posedge oen) en_seen = 1'b1;
   // short self-timed cycles keep the run brief
   flash_id_sec_cmd #(.ERASE_TIME_US(6), .PROG_TIME_US(1)) i_flash_id_sec_cmd (.core_clk_i(core_clk_i),
      .nrst_i(nrst_i), .ce_i(1'b1), .sclk_i(sclk), .cs_n_i(cs_n), .serial_in_i(mosi), .serial_out_o(miso),
      .serial_out_en_o(oen), .addr4_mode_i(addr4), .other_busy_i(obusy), .wen_set_i(wen),
      .security_otp_lock_bits_i(lock), .busy_o(busy), .write_enable_latch_o(latch));
   // a released pin shows the inverse, so a missing enable cannot pass
   spi_host_model i_spi_host_model (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(oen ? miso : ~miso));
   task chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask : chk
   task tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   task wait_busy(input logic lvl, input int bound);
      int n;
      n = 0;
      while (busy !== lvl && n < bound)
      begin
         @(posedge core_clk_i);
         n++;
      end
      if (busy !== lvl)
      begin
         miscompares++;
         tally_and_finish();
      end
   endtask : wait_busy
   // status levels settle well before the next frame
   task set_st(input logic a4, input logic ob, input logic [2:0] lk);
      @(posedge core_clk_i);
      addr4 <= a4;
      obusy <= ob;
      lock <= lk;
      #200;
   endtask : set_st
   task pulse_wen;
      @(posedge core_clk_i) wen <= 1'b1;
      @(posedge core_clk_i) wen <= 1'b0;
   endtask : pulse_wen
   task t_ids;
      i_spi_host_model.frame({OPC_JEDEC, 56'h0}, 8, 24, rx);
      chk("jedec", rx, {40'h0, MFR_ID, MEM_TYPE_ID, CAPACITY_ID});
      i_spi_host_model.frame({OPC_UID, 56'h0}, 40, 64, rx);
      chk("uid3", rx, UNIQUE_ID);
      set_st(1'b1, 1'b0, 3'h0);
      i_spi_host_model.frame({OPC_UID, 56'h0}, 48, 64, rx);
      chk("uid4", rx, UNIQUE_ID);
      i_spi_host_model.frame({OPC_SFDP, 24'h0000FF, 32'h0}, 40, 16, rx);
      chk("sfdp", rx, 64'hFF53);
      set_st(1'b0, 1'b0, 3'h0);
   endtask : t_ids
   // program across the wrap point, then a refused one
   task t_prog;
      pulse_wen();
      i_spi_host_model.frame({OPC_SEC_PRG, 24'h0010FF, 16'hA53C, 16'h0}, 48, 0, rx);
      wait_busy(1'b1, 20);
      wait_busy(1'b0, 80);
      chk("wen_prog", latch, 1'b0);
      i_spi_host_model.frame({OPC_SEC_RD, 24'h0010FF, 32'h0}, 40, 16, rx);
      chk("rd_wrap", rx, 64'hA53C);
      i_spi_host_model.frame({OPC_SEC_PRG, 24'h001000, 8'h00, 24'h0}, 40, 0, rx);
      chk("no_wen", busy, 1'b0);
   endtask : t_prog
   task t_erase;
      pulse_wen();
      i_spi_host_model.frame({OPC_SEC_ERS, 24'h001000, 32'h0}, 33, 0, rx);
      chk("ers_extra", busy, 1'b0);
      i_spi_host_model.frame({OPC_SEC_ERS, 24'h001000, 32'h0}, 32, 0, rx);
      en_seen = 1'b0;
      i_spi_host_model.frame({OPC_SEC_RD, 24'h0010FF, 32'h0}, 40, 8, rx);
      chk("busy_rd", {busy, en_seen}, 2'b10);
      wait_busy(1'b0, 400);
      chk("wen_ers", latch, 1'b0);
      i_spi_host_model.frame({OPC_SEC_RD, 24'h0010FF, 32'h0}, 40, 16, rx);
      chk("erased", rx, 64'hFFFF);
   endtask : t_erase
   task t_guard;
      set_st(1'b0, 1'b0, 3'h1);
      pulse_wen();
      i_spi_host_model.frame({OPC_SEC_ERS, 24'h001000, 32'h0}, 32, 0, rx);
      chk("locked", busy, 1'b0);
      set_st(1'b0, 1'b1, 3'h1);
      en_seen = 1'b0;
      i_spi_host_model.frame({OPC_SEC_RD, 24'h002000, 32'h0}, 40, 8, rx);
      chk("other_busy", en_seen, 1'b0);
      set_st(1'b0, 1'b0, 3'h1);
      i_spi_host_model.frame({OPC_SEC_RD, 24'h004000, 32'h0}, 40, 8, rx);
      chk("bad_addr", en_seen, 1'b0);
      set_st(1'b1, 1'b0, 3'h1);
      i_spi_host_model.frame({OPC_SEC_RD, 32'h00003000, 24'h0}, 48, 8, rx);
      chk("rd4", rx, 64'hFF);
   endtask : t_guard
   initial
   begin
      repeat (12) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      t_ids();
      t_prog();
      t_erase();
      t_guard();
      tally_and_finish();
   end
endmodule : test_flash_id_sec_cmd
